// ### fvac_core.sv
// Command interpreter for PF assignment and VF allocation packets.
// Assumes a packet parser upstream delivers decoded payload words and a
// framer downstream adds header, checksum and padding; one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "fvac_map.svh"

// Behaviour
// - Channel map 32 bits, bits 0-15 one per function, upper bits zero.
// - Assigned disabled functions still get partition commands.
// - Channel map bits 0-15 are functions 0-15.
// - Enable map bits 0-15 enable functions.
// - Endpoint map bits 0-15 place functions.
// - Good set-assignment replies with type 0xA8.
// - VF query is type 0x35, no parameters.
// - Good VF query replies with type 0xB5.
// - Reply byte per function, function 0 first.
// - VF set command is type 0x36.
// - Set payload byte per function, function 0 first.
// - VF counts pending until next PCI reset.
// - Stored allocation persists until replaced.
// - Function assignment set command is type 0x28.
// - PF assignments pending until PCI reset, persistent.
module fvac_core #(
  parameter int NUM_PF = 16,
  parameter int VF_W   = 8
) (
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    cmd_valid_in,
  input  wire fvac_pkg::fvac_cmd_t     cmd_in,
  input  wire logic [15:0]             vf_capacity_in,
  input  wire logic                    pci_reset_in,
  input  wire logic                    rsp_ready_in,
  output logic                         cmd_ready_out,
  output logic                         rsp_valid_out,
  output fvac_pkg::fvac_rsp_t          rsp_out,
  output logic [31:0]                  active_chan_map_out,
  output logic [31:0]                  active_enable_map_out,
  output logic [31:0]                  active_endpoint_map_out,
  output logic [NUM_PF*VF_W-1:0]       active_vf_out,
  output logic                         function_zero_bit_out
);

  typedef struct packed {
    fvac_pkg::fvac_state_t state;
    fvac_pkg::fvac_rsp_t   rsp;
    logic [31:0]           pend_chan;
    logic [31:0]           pend_enable;
    logic [31:0]           pend_endpoint;
    logic [31:0]           act_chan;
    logic [31:0]           act_enable;
    logic [31:0]           act_endpoint;
    logic [NUM_PF*VF_W-1:0] pend_vf;
    logic [NUM_PF*VF_W-1:0] act_vf;
    logic                  pci_q1;
    logic                  pci_q2;
  } fvac_core_state_t;

  fvac_core_state_t st_reg;
  fvac_core_state_t st_next;
  logic [15:0]      vf_sum;
  logic [NUM_PF*VF_W-1:0] req_vf;
  logic [NUM_PF*VF_W-1:0] rpt_vf;
  logic [31:0]      used_mask;
  logic             take_cmd;
  logic             take_set_pf;
  logic             take_get_vf;
  logic             take_set_vf;

  // Function 0 sits in the most significant byte lane, so the request is
  // flipped into an array indexed by function number.
  for (genvar g = 0; g < NUM_PF; g++) begin : g_lane
    assign req_vf[g*VF_W +: VF_W] = cmd_in.vf_req[NUM_PF*VF_W-1-g*VF_W -: VF_W];
    assign rpt_vf[NUM_PF*VF_W-1-g*VF_W -: VF_W] = st_reg.act_vf[g*VF_W +: VF_W];
  end

  // Sixteen bits hold the sum of any sensible number of byte lanes, so the
  // capacity compare never sees a wrapped total.
  always_comb begin
    vf_sum = 16'h0000;
    for (int i = 0; i < NUM_PF; i++) begin
      vf_sum = vf_sum + 16'(req_vf[i*VF_W +: VF_W]);
    end
  end

  // Only bits 0 through 15 name functions; upper bits are stored as zero.
  assign used_mask = {{(`FVAC_MAP_WIDTH-`FVAC_PF_USED){1'b0}}, {`FVAC_PF_USED{1'b1}}};

  always_comb begin
    st_next = st_reg;
    st_next.pci_q1 = pci_reset_in;
    st_next.pci_q2 = st_reg.pci_q1;
    // Pending values take effect on each clock while the twice-registered PCI reset is high.
    if (st_reg.pci_q2) begin
      st_next.act_chan     = st_reg.pend_chan;
      st_next.act_enable   = st_reg.pend_enable;
      st_next.act_endpoint = st_reg.pend_endpoint;
      st_next.act_vf       = st_reg.pend_vf;
    end
    case (st_reg.state)
      fvac_pkg::FVAC_IDLE: begin
        if (cmd_valid_in) begin
          st_next.state = fvac_pkg::FVAC_REPLY;
          st_next.rsp.rsp_code = `FVAC_RSP_OK;
          st_next.rsp.reason_code = `FVAC_RSN_NONE;
          st_next.rsp.vf_report = '0;
          case (cmd_in.cmd_type)
            `FVAC_CMD_SET_PF: begin
              // Assignment kept whether or not the function is enabled,
              // so disabled functions stay addressable.
              st_next.pend_chan     = cmd_in.chan_map & used_mask;
              st_next.pend_enable   = cmd_in.enable_map & used_mask;
              st_next.pend_endpoint = cmd_in.endpoint_map & used_mask;
              st_next.rsp.rsp_type  = `FVAC_RSP_SET_PF;
            end
            `FVAC_CMD_GET_VF: begin
              st_next.rsp.rsp_type  = `FVAC_RSP_GET_VF;
              st_next.rsp.vf_report = rpt_vf;
            end
            `FVAC_CMD_SET_VF: begin
              st_next.rsp.rsp_type = `FVAC_RSP_SET_VF;
              // The sum is checked here too, since a bad request would
              // otherwise corrupt configuration space at reset.
              if (vf_sum > vf_capacity_in) begin
                st_next.rsp.rsp_code    = `FVAC_RSP_FAIL;
                st_next.rsp.reason_code = `FVAC_RSN_VF_TOTAL;
              end else begin
                st_next.pend_vf = req_vf;
              end
            end
            default: begin
              st_next.rsp.rsp_type    = cmd_in.cmd_type | `FVAC_RSP_FLAG;
              st_next.rsp.rsp_code    = `FVAC_RSP_FAIL;
              st_next.rsp.reason_code = `FVAC_RSN_UNKNOWN;
            end
          endcase
        end
      end
      fvac_pkg::FVAC_REPLY: begin
        if (rsp_ready_in) begin
          st_next.state = fvac_pkg::FVAC_IDLE;
        end
      end
      default: st_next.state = fvac_pkg::FVAC_IDLE;
    endcase
    if (!rst_n_in) begin
      st_next = '0;
      st_next.state = fvac_pkg::FVAC_IDLE;
    end
  end

  always_ff @(posedge clk_in) begin
    st_reg <= st_next;
  end

  assign cmd_ready_out           = (st_reg.state == fvac_pkg::FVAC_IDLE);
  assign rsp_valid_out           = (st_reg.state == fvac_pkg::FVAC_REPLY);
  assign rsp_out                 = st_reg.rsp;
  assign active_chan_map_out     = st_reg.act_chan;
  assign active_enable_map_out   = st_reg.act_enable;
  assign active_endpoint_map_out = st_reg.act_endpoint;
  assign active_vf_out           = st_reg.act_vf;
  assign function_zero_bit_out   = st_reg.act_enable[0];

  assign take_cmd    = cmd_ready_out && cmd_valid_in;
  assign take_set_pf = take_cmd && (cmd_in.cmd_type == `FVAC_CMD_SET_PF);
  assign take_get_vf = take_cmd && (cmd_in.cmd_type == `FVAC_CMD_GET_VF);
  assign take_set_vf = take_cmd && (cmd_in.cmd_type == `FVAC_CMD_SET_VF);

  // Commands are judged at the edge that takes them and their effect one edge
  // later, once the reply and the pending copies have been registered.
  AST_PF_REPLY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cmd_ready_out && cmd_valid_in && cmd_in.cmd_type == `FVAC_CMD_SET_PF
    |=> rsp_valid_out && rsp_out.rsp_type == `FVAC_RSP_SET_PF)
    else $error("set assignment reply type wrong");

  AST_PF_CODE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_set_pf
    |=> rsp_out.rsp_code == `FVAC_RSP_OK && rsp_out.reason_code == `FVAC_RSN_NONE)
    else $error("set assignment reply not clean");

  AST_CHAN_STORE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_set_pf
    |=> st_reg.pend_chan == ($past(cmd_in.chan_map) & used_mask))
    else $error("channel map not stored");

  AST_ENABLE_STORE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_set_pf
    |=> st_reg.pend_enable == ($past(cmd_in.enable_map) & used_mask))
    else $error("enable map not stored");

  AST_ENDPOINT_STORE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_set_pf
    |=> st_reg.pend_endpoint == ($past(cmd_in.endpoint_map) & used_mask))
    else $error("endpoint map not stored");

  AST_DISABLED_KEPT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_set_pf && cmd_in.chan_map[0] && !cmd_in.enable_map[0]
    |=> st_reg.pend_chan[0])
    else $error("disabled function lost its channel");

  AST_PF_ONLY_MAPS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_set_pf
    |=> $stable(st_reg.pend_vf))
    else $error("set assignment touched vf counts");

  AST_GET_REPLY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cmd_ready_out && cmd_valid_in && cmd_in.cmd_type == `FVAC_CMD_GET_VF
    |=> rsp_valid_out && rsp_out.rsp_type == `FVAC_RSP_GET_VF)
    else $error("vf query reply type wrong");

  AST_GET_CODE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_get_vf
    |=> rsp_out.rsp_code == `FVAC_RSP_OK && rsp_out.reason_code == `FVAC_RSN_NONE)
    else $error("vf query reply not clean");

  AST_GET_DATA: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cmd_ready_out && cmd_valid_in && cmd_in.cmd_type == `FVAC_CMD_GET_VF && !st_reg.pci_q2
    |=> rsp_out.vf_report[NUM_PF*VF_W-1 -: VF_W] == $past(st_reg.act_vf[VF_W-1:0]))
    else $error("function 0 count not in top lane");

  AST_GET_LAST: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_get_vf
    |=> rsp_out.vf_report[VF_W-1:0] == $past(st_reg.act_vf[NUM_PF*VF_W-1 -: VF_W]))
    else $error("last function count not in bottom lane");

  AST_GET_NO_WRITE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_get_vf
    |=> $stable(st_reg.pend_vf) && $stable(st_reg.pend_chan))
    else $error("vf query changed pending settings");

  AST_VF_REPLY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_set_vf
    |=> rsp_valid_out && rsp_out.rsp_type == `FVAC_RSP_SET_VF)
    else $error("vf set reply type wrong");

  AST_REJECT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cmd_ready_out && cmd_valid_in && cmd_in.cmd_type == `FVAC_CMD_SET_VF
    && vf_sum > vf_capacity_in
    |=> rsp_out.rsp_code == `FVAC_RSP_FAIL && $stable(st_reg.pend_vf))
    else $error("over capacity request not rejected");

  AST_REJECT_REASON: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_set_vf && vf_sum > vf_capacity_in
    |=> rsp_out.reason_code == `FVAC_RSN_VF_TOTAL)
    else $error("over capacity reason wrong");

  AST_STORE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cmd_ready_out && cmd_valid_in && cmd_in.cmd_type == `FVAC_CMD_SET_VF
    && vf_sum <= vf_capacity_in
    |=> st_reg.pend_vf[VF_W-1:0] == $past(cmd_in.vf_req[NUM_PF*VF_W-1 -: VF_W]))
    else $error("vf request not stored");

  AST_STORE_LAST: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_set_vf && vf_sum <= vf_capacity_in
    |=> st_reg.pend_vf[NUM_PF*VF_W-1 -: VF_W] == $past(cmd_in.vf_req[VF_W-1:0]))
    else $error("last function request not stored");

  AST_VF_KEEP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !take_set_vf
    |=> $stable(st_reg.pend_vf))
    else $error("pending vf counts changed without a set");

  AST_UNKNOWN_KEEP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_cmd && !take_set_pf && !take_get_vf && !take_set_vf
    |=> rsp_out.rsp_code == `FVAC_RSP_FAIL && $stable(st_reg.pend_chan))
    else $error("unknown command not refused");

  AST_PF_KEEP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !take_set_pf
    |=> $stable(st_reg.pend_chan) && $stable(st_reg.pend_enable)
    && $stable(st_reg.pend_endpoint))
    else $error("pending maps changed without a set");

  AST_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !st_reg.pci_q2 |=> $stable(active_vf_out) && $stable(active_chan_map_out))
    else $error("active settings changed without pci reset");

  AST_HOLD_MAPS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !st_reg.pci_q2
    |=> $stable(active_enable_map_out) && $stable(active_endpoint_map_out))
    else $error("active maps changed without pci reset");

  AST_APPLY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    st_reg.pci_q2 |=> active_chan_map_out == $past(st_reg.pend_chan)
    && active_vf_out == $past(st_reg.pend_vf))
    else $error("pending settings not applied");

  AST_APPLY_MAPS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    st_reg.pci_q2 |=> active_enable_map_out == $past(st_reg.pend_enable)
    && active_endpoint_map_out == $past(st_reg.pend_endpoint))
    else $error("pending maps not applied");

  AST_UPPER: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (st_reg.pend_chan & ~used_mask) == `FVAC_ZERO32
    && (st_reg.pend_enable & ~used_mask) == `FVAC_ZERO32)
    else $error("unused function bits stored");

  AST_UPPER_EP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (st_reg.pend_endpoint & ~used_mask) == `FVAC_ZERO32)
    else $error("unused endpoint bits stored");

  AST_REPLY_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rsp_valid_out && !rsp_ready_in |=> rsp_valid_out && $stable(rsp_out))
    else $error("reply dropped before taken");

endmodule
`default_nettype wire

// ### fvac_map.svh
// Constants for the function and VF allocation command block.
// Assumes inclusion by the package, the design module and the bench.
`ifndef FVAC_MAP_SVH
`define FVAC_MAP_SVH
`define FVAC_CMD_SET_PF      8'h28
`define FVAC_CMD_GET_VF      8'h35
`define FVAC_CMD_SET_VF      8'h36
`define FVAC_RSP_SET_PF      8'hA8
`define FVAC_RSP_GET_VF      8'hB5
`define FVAC_RSP_SET_VF      8'hA8
`define FVAC_RSP_FLAG        8'h80
`define FVAC_RSP_OK          16'h0000
`define FVAC_RSP_FAIL        16'h0001
`define FVAC_RSN_NONE        16'h0000
`define FVAC_RSN_VF_TOTAL    16'h0001
`define FVAC_RSN_UNKNOWN     16'h0003
`define FVAC_MAP_WIDTH       32
`define FVAC_PF_USED         16
`define FVAC_ZERO32          32'h0000_0000
`endif

// ### fvac_pkg.sv
// Types for the function and VF allocation command block.
// Assumes fvac_map.svh is on the include path.
`default_nettype none
`include "fvac_map.svh"
package fvac_pkg;
  typedef struct packed {
    logic [7:0]  cmd_type;
    logic [31:0] chan_map;
    logic [31:0] enable_map;
    logic [31:0] endpoint_map;
    logic [127:0] vf_req;
  } fvac_cmd_t;
  typedef struct packed {
    logic [7:0]  rsp_type;
    logic [15:0] rsp_code;
    logic [15:0] reason_code;
    logic [127:0] vf_report;
  } fvac_rsp_t;
  typedef enum logic [1:0] {FVAC_IDLE, FVAC_REPLY} fvac_state_t;
endpackage
`default_nettype wire

// ### fvac_sink.sv
// Reply sink standing in for the framer behind the command block.
// Assumes one clock; ready changes only on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module fvac_sink (
  input  wire logic clk_in,
  input  wire logic slow_in,
  output logic      rsp_ready_out
);
  integer seed = 32'h075A344C;
  initial rsp_ready_out = 1'b0;
  // Slow mode stalls most cycles, so replies must stand while held.
  always @(negedge clk_in) rsp_ready_out <= slow_in ? ($random(seed) % 4 == 0) : 1'b1;
endmodule
`default_nettype wire

// ### function_vf_allocation_cmds_test.sv
// Self-checking bench for the function and VF allocation command block.
// Assumes fvac_map.svh on the include path and the sink model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "fvac_map.svh"
module function_vf_allocation_cmds_test;
  logic                clk_in, rst_n_in, cmd_valid_in, pci_reset_in, rsp_ready_in, slow;
  logic                cmd_ready_out, rsp_valid_out, function_zero_bit_out;
  logic [15:0]         vf_capacity_in;
  logic [31:0]         chan, ena, endp, ac, ae, ap, pc;
  logic [127:0]        req, cur, act_vf;
  fvac_pkg::fvac_cmd_t cmd_in;
  fvac_pkg::fvac_rsp_t rsp_out, e;
  fvac_pkg::fvac_rsp_t exp_q[$];
  bit                  full_q[$];
  integer              seed = 32'h075A344C;
  int                  mismatches, num_checks, sum;
  fvac_core i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in), .vf_capacity_in(vf_capacity_in), .pci_reset_in(pci_reset_in),
    .rsp_ready_in(rsp_ready_in), .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_out(rsp_out), .active_chan_map_out(ac), .active_enable_map_out(ae),
    .active_endpoint_map_out(ap), .active_vf_out(act_vf),
    .function_zero_bit_out(function_zero_bit_out));
  fvac_sink i_sink (.clk_in(clk_in), .slow_in(slow), .rsp_ready_out(rsp_ready_in));
  task automatic check(input logic [167:0] seen, input logic [167:0] want);
    num_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  function automatic logic [127:0] rev(input logic [127:0] v);
    for (int i = 0; i < 16; i++) rev[i*8 +: 8] = v[127-i*8 -: 8];
  endfunction
  task automatic send(input logic [7:0] t, input logic [127:0] vf, input logic [7:0] rt,
                      input logic [15:0] rc, input logic [15:0] rs, input logic [127:0] rep,
                      input bit full);
    @(negedge clk_in);
    for (int i = 0; i < 50 && cmd_ready_out !== 1'b1; i++) @(negedge clk_in);
    check(cmd_ready_out, 1'b1);
    cmd_in = '{t, chan, ena, endp, vf};
    cmd_valid_in = 1'b1;
    exp_q.push_back('{rt, rc, rs, rep});
    full_q.push_back(full);
    @(negedge clk_in);
    cmd_valid_in = 1'b0;
  endtask
  task automatic pci;
    @(negedge clk_in);
    pci_reset_in = 1'b1;
    @(negedge clk_in);
    pci_reset_in = 1'b0;
    repeat (5) @(negedge clk_in);
  endtask
  task automatic summarize;
    if (exp_q.size() != 0) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %0d replies missing", $time, exp_q.size());
    end
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Replies are judged only at the edge where the sink accepts them.
  always @(posedge clk_in) begin
    if (rst_n_in === 1'b1 && rsp_valid_out === 1'b1 && rsp_ready_in === 1'b1) begin
      if (exp_q.size() == 0) check(rsp_valid_out, 1'b0);
      else begin
        e = exp_q.pop_front();
        if (full_q.pop_front()) check(rsp_out, e);
        else check(rsp_out[167:128], e[167:128]);
      end
    end
  end
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  initial begin
    #200000;
    mismatches++;
    summarize;
  end
  initial begin
    {rst_n_in, cmd_valid_in, pci_reset_in, slow, chan, ena, endp} = '0;
    cmd_in = '0;
    cur = '0;
    pc = '0;
    vf_capacity_in = 16'h0800;
    repeat (6) @(negedge clk_in);
    rst_n_in = 1'b1;
    for (int p = 0; p < 2; p++) begin
      slow = p[0];
      chan = $random(seed);
      ena = $random(seed);
      endp = $random(seed);
      sum = 0;
      for (int i = 0; i < 16; i++) begin
        req[i*8 +: 8] = 8'($random(seed)) & 8'h7F;
        sum += req[i*8 +: 8];
      end
      // The second pass sets the capacity to the exact request total.
      vf_capacity_in = p[0] ? 16'(sum) : 16'h0800;
      send(`FVAC_CMD_SET_PF, '0, `FVAC_RSP_SET_PF, `FVAC_RSP_OK, `FVAC_RSN_NONE, '0, 0);
      send(`FVAC_CMD_SET_VF, req, `FVAC_RSP_SET_VF, `FVAC_RSP_OK, `FVAC_RSN_NONE, '0, 0);
      send(`FVAC_CMD_SET_VF, {16{8'hFF}}, `FVAC_RSP_SET_VF, `FVAC_RSP_FAIL,
           `FVAC_RSN_VF_TOTAL, '0, 0);
      send(`FVAC_CMD_GET_VF, '0, `FVAC_RSP_GET_VF, `FVAC_RSP_OK, `FVAC_RSN_NONE, cur, 1);
      send(8'h29, '0, 8'hA9, `FVAC_RSP_FAIL, `FVAC_RSN_UNKNOWN, '0, 0);
      check(ac, pc);
      pci;
      cur = req;
      pc = {16'h0000, chan[15:0]};
      check(ac, pc);
      check(ae, {16'h0000, ena[15:0]});
      check(ap, {16'h0000, endp[15:0]});
      check(function_zero_bit_out, ena[0]);
      check(act_vf, rev(req));
      send(`FVAC_CMD_GET_VF, '0, `FVAC_RSP_GET_VF, `FVAC_RSP_OK, `FVAC_RSN_NONE, cur, 1);
      for (int i = 0; i < 200 && exp_q.size() != 0; i++) @(negedge clk_in);
      $display("test %0d done", p);
    end
    summarize;
  end
endmodule
`default_nettype wire
